// >>> core/eax_pkg.sv
package eax_pkg;

    // datapath geometry
    localparam int DATA_W    = 8;
    localparam int NIB_W     = 4;
    localparam int BIT_SEL_W = 3;
    localparam int MSB       = DATA_W - 1;
    localparam int LSB       = 0;

    // fixed byte values
    localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;

    // reset values of the architectural state
    localparam logic [DATA_W-1:0] WORKING_RESET = 8'h00;

    // a taken skip replaces the next instruction by this many dummy cycles
    localparam int DUMMY_CYCLES = 1;
    localparam int DUMMY_CNT_W  = 2;

    // operations of this execute group
    typedef enum logic [4:0] {
        OP_OR_TO_WORKING,
        OP_OR_TO_MEMORY,
        OP_ROTATE_LEFT_MEM,
        OP_ROTATE_LEFT_TO_WORKING,
        OP_ROTATE_LEFT_THRU_CARRY_MEM,
        OP_ROTATE_LEFT_THRU_CARRY_WORKING,
        OP_ROTATE_RIGHT_MEM,
        OP_ROTATE_RIGHT_TO_WORKING,
        OP_ROTATE_RIGHT_THRU_CARRY_MEM,
        OP_ROTATE_RIGHT_THRU_CARRY_WORKING,
        OP_SUBTRACT_BORROW_WORKING,
        OP_SUBTRACT_BORROW_MEMORY,
        OP_SUBTRACT_WORKING,
        OP_SUBTRACT_MEMORY,
        OP_DECREMENT_SKIP_ZERO,
        OP_DECREMENT_SKIP_ZERO_WORKING,
        OP_INCREMENT_SKIP_ZERO,
        OP_INCREMENT_SKIP_ZERO_WORKING,
        OP_SET_ALL,
        OP_SET_BIT,
        OP_SKIP_IF_NONZERO,
        OP_SKIP_IF_NONZERO_BIT,
        OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_WORKING
    } eax_op_e;

    // status flags kept by the core
    typedef struct packed {
        logic chainedNullFlag;
        logic signedChainFlag;
        logic overflowFlag;
        logic halfCarryFlag;
        logic zeroFlag;
        logic carryFlag;
    } eax_flags_s;

    localparam eax_flags_s FLAGS_RESET = '0;

    // one issued instruction
    typedef struct packed {
        eax_op_e                code;
        logic [BIT_SEL_W-1:0]   bitSel;
    } eax_instr_s;

    // outcome of one operation
    typedef struct packed {
        logic [DATA_W-1:0]      data;
        eax_flags_s             flags;
        logic                   toWorking;
        logic                   toMemory;
        logic                   skip;
    } eax_result_s;

endpackage

// >>> core/eax_alu.sv
`timescale 1ns/10ps

module eax_alu
    import eax_pkg::*;
(
    input  wire eax_instr_s        instr,
    input  wire logic [DATA_W-1:0] working,
    input  wire logic [DATA_W-1:0] memByte,
    input  wire eax_flags_s        flagsIn,
    output eax_result_s            result
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic isZero(input logic [DATA_W-1:0] v);
        isZero = (v == BYTE_ZERO);
    endfunction

    // subtract with borrow in; returns {carry, halfCarry, overflow, diff}
    // carry is the inverted borrow: clear when negative, set otherwise
    function automatic logic [DATA_W+2:0] sub8(input logic [DATA_W-1:0] a,
                                               input logic [DATA_W-1:0] b,
                                               input logic              borrow);
        logic [DATA_W:0]  full;
        logic [NIB_W:0]   low;
        logic             ov;
        full = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, borrow};
        low  = {1'b0, a[NIB_W-1:0]} - {1'b0, b[NIB_W-1:0]} - {{NIB_W{1'b0}}, borrow};
        ov   = (a[MSB] ^ b[MSB]) & (a[MSB] ^ full[MSB]);
        sub8 = {~full[DATA_W], ~low[NIB_W], ov, full[DATA_W-1:0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // operation decode; flags start as the old ones so untouched ones hold

    always_comb begin
        logic [DATA_W+2:0] diff;
        logic              withBorrow;
        result           = '0;
        result.flags     = flagsIn;
        withBorrow       = (instr.code == OP_SUBTRACT_BORROW_WORKING) ||
                           (instr.code == OP_SUBTRACT_BORROW_MEMORY);
        // borrow in is the inverted carry for the borrow forms only
        diff             = sub8(working, memByte, withBorrow & ~flagsIn.carryFlag);
        unique case (instr.code)
            OP_OR_TO_WORKING, OP_OR_TO_MEMORY: begin
                result.data           = working | memByte;
                result.flags.zeroFlag = isZero(working | memByte);
                result.toWorking      = (instr.code == OP_OR_TO_WORKING);
                result.toMemory       = (instr.code == OP_OR_TO_MEMORY);
            end
            OP_ROTATE_LEFT_MEM, OP_ROTATE_LEFT_TO_WORKING: begin
                result.data      = {memByte[MSB-1:LSB], memByte[MSB]};
                result.toWorking = (instr.code == OP_ROTATE_LEFT_TO_WORKING);
                result.toMemory  = (instr.code == OP_ROTATE_LEFT_MEM);
            end
            OP_ROTATE_LEFT_THRU_CARRY_MEM, OP_ROTATE_LEFT_THRU_CARRY_WORKING: begin
                result.data            = {memByte[MSB-1:LSB], flagsIn.carryFlag};
                result.flags.carryFlag = memByte[MSB];
                result.toWorking = (instr.code == OP_ROTATE_LEFT_THRU_CARRY_WORKING);
                result.toMemory  = (instr.code == OP_ROTATE_LEFT_THRU_CARRY_MEM);
            end
            OP_ROTATE_RIGHT_MEM, OP_ROTATE_RIGHT_TO_WORKING: begin
                result.data      = {memByte[LSB], memByte[MSB:LSB+1]};
                result.toWorking = (instr.code == OP_ROTATE_RIGHT_TO_WORKING);
                result.toMemory  = (instr.code == OP_ROTATE_RIGHT_MEM);
            end
            OP_ROTATE_RIGHT_THRU_CARRY_MEM, OP_ROTATE_RIGHT_THRU_CARRY_WORKING: begin
                result.data            = {flagsIn.carryFlag, memByte[MSB:LSB+1]};
                result.flags.carryFlag = memByte[LSB];
                result.toWorking = (instr.code == OP_ROTATE_RIGHT_THRU_CARRY_WORKING);
                result.toMemory  = (instr.code == OP_ROTATE_RIGHT_THRU_CARRY_MEM);
            end
            OP_SUBTRACT_BORROW_WORKING, OP_SUBTRACT_BORROW_MEMORY,
            OP_SUBTRACT_WORKING, OP_SUBTRACT_MEMORY: begin
                result.data                  = diff[DATA_W-1:0];
                result.flags.carryFlag       = diff[DATA_W+2];
                result.flags.halfCarryFlag   = diff[DATA_W+1];
                result.flags.overflowFlag    = diff[DATA_W];
                result.flags.zeroFlag        = isZero(diff[DATA_W-1:0]);
                result.flags.signedChainFlag = diff[DATA_W] ^ diff[MSB];
                // borrow forms chain the zero over bytes, plain forms restart it
                result.flags.chainedNullFlag = isZero(diff[DATA_W-1:0]) &
                                               (~withBorrow | flagsIn.chainedNullFlag);
                result.toWorking = (instr.code == OP_SUBTRACT_BORROW_WORKING) ||
                                   (instr.code == OP_SUBTRACT_WORKING);
                result.toMemory  = (instr.code == OP_SUBTRACT_BORROW_MEMORY) ||
                                   (instr.code == OP_SUBTRACT_MEMORY);
            end
            OP_DECREMENT_SKIP_ZERO, OP_DECREMENT_SKIP_ZERO_WORKING: begin
                result.data      = memByte - BYTE_ONE;
                result.skip      = isZero(memByte - BYTE_ONE);
                result.toWorking = (instr.code == OP_DECREMENT_SKIP_ZERO_WORKING);
                result.toMemory  = (instr.code == OP_DECREMENT_SKIP_ZERO);
            end
            OP_INCREMENT_SKIP_ZERO, OP_INCREMENT_SKIP_ZERO_WORKING: begin
                result.data      = memByte + BYTE_ONE;
                result.skip      = isZero(memByte + BYTE_ONE);
                result.toWorking = (instr.code == OP_INCREMENT_SKIP_ZERO_WORKING);
                result.toMemory  = (instr.code == OP_INCREMENT_SKIP_ZERO);
            end
            OP_SET_ALL: begin
                result.data     = BYTE_ONES;
                result.toMemory = 1'b1;
            end
            OP_SET_BIT: begin
                result.data     = memByte | (BYTE_ONE << instr.bitSel);
                result.toMemory = 1'b1;
            end
            OP_SKIP_IF_NONZERO: begin
                result.data = memByte;
                result.skip = ~isZero(memByte);
            end
            OP_SKIP_IF_NONZERO_BIT: begin
                result.data = memByte;
                result.skip = memByte[instr.bitSel];
            end
            OP_NIBBLE_EXCHANGE, OP_NIBBLE_EXCHANGE_WORKING: begin
                result.data      = {memByte[NIB_W-1:0], memByte[DATA_W-1:NIB_W]};
                result.toWorking = (instr.code == OP_NIBBLE_EXCHANGE_WORKING);
                result.toMemory  = (instr.code == OP_NIBBLE_EXCHANGE);
            end
            // codes past the last operation write nothing and leave the flags alone
            default: begin
                result.data = memByte;
            end
        endcase
    end

endmodule

// >>> core/eax_execute.sv
`timescale 1ns/10ps

// How it works
// - OR working register with memory byte into working register; only zero flag moves.
// - OR result written back into memory byte; only zero flag moves.
// - Rotate byte left, top bit wraps to bit zero; no flags; memory or working.
// - Rotate left through carry: carry into bit zero, bit seven into carry.
// - Rotate byte right, bit zero wraps to bit seven; no flags; memory or working.
// - Rotate right through carry: carry into bit seven, bit zero into carry.
// - Working minus byte minus inverted carry into working; six flags updated.
// - Same borrow subtraction, difference written to memory byte instead.
// - Subtraction carry clears on negative result, sets on zero or positive.
// - Plain subtraction without borrow, to working or memory, same six flags.
// - A taken skip inserts one dummy cycle in place of the next instruction.
// - Decrement byte into memory, skip when new value is zero, flags unchanged.
// - Decremented byte into working register, memory kept, skip when zero.
// - Increment byte into memory, skip when new value is zero, flags unchanged.
// - Incremented byte into working register, memory kept, skip when zero.
// - Set-byte writes all ones into memory byte, flags unchanged.
// - Set-bit forces selected bit to one, other bits kept, flags unchanged.
// - Bit test skips when selected bit is one, proceeds when zero.
// - Byte test skips when whole byte is nonzero, proceeds when zero.
// - Nibble swap exchanges halves of memory byte in place, flags unchanged.
// - Working-register nibble swap writes swapped byte to working, memory kept.
// - Memory high nibble lands in working low nibble and vice versa.
module eax_execute
    import eax_pkg::*;
#(
    parameter int ADDR_W = 9
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // instruction issue from the sequencer
    input  wire logic              instrValid,
    input  wire eax_instr_s        instr,
    input  wire logic [ADDR_W-1:0] instrAddr,
    output logic                   instrReady,
    // direct loads of architectural state by the rest of the core
    input  wire logic              workingLoad,
    input  wire logic [DATA_W-1:0] workingLoadData,
    input  wire logic              flagsLoad,
    input  wire eax_flags_s        flagsLoadData,
    // operand read strobe and answer from data memory
    output logic                   memRdReq,
    output logic [ADDR_W-1:0]      memAddr,
    input  wire logic              memRdValid,
    input  wire logic [DATA_W-1:0] memRdData,
    // write-back strobe to data memory
    output logic                   memWrEn,
    output logic [DATA_W-1:0]      memWrData,
    // skip request and completion towards the sequencer
    output logic                   skipReq,
    output logic                   dummyCycle,
    output logic                   instrDone,
    // architectural state
    output logic [DATA_W-1:0]      working,
    output eax_flags_s             flags
);

    ////////////////////////////////////////////////////////////////////////////
    // state and declarations

    typedef enum {
        ST_IDLE,
        ST_READ,
        ST_DUMMY
    } eax_state_e;

    eax_state_e              state;
    eax_state_e              next_state;
    eax_instr_s              heldInstr;
    eax_result_s             aluResult;
    logic                    commit;
    logic [DUMMY_CNT_W-1:0]  dummyCnt;

    localparam logic [DUMMY_CNT_W-1:0] DUMMY_LAST = DUMMY_CNT_W'(DUMMY_CYCLES - 1);
    localparam logic [DUMMY_CNT_W-1:0] CNT_ZERO   = '0;
    localparam logic [DUMMY_CNT_W-1:0] CNT_ONE    = DUMMY_CNT_W'(1);

    ////////////////////////////////////////////////////////////////////////////
    // handshakes

    // the block takes a new instruction only when nothing is in flight
    assign instrReady = (state == ST_IDLE);

    // operand strobe stays high until memory answers
    assign memRdReq   = (state == ST_READ);

    // the operand arrives and the operation completes in the same cycle
    assign commit     = (state == ST_READ) && memRdValid;

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    // the alu sees the held instruction and the byte as it comes back
    eax_alu u_alu (
        .instr   (heldInstr),
        .working (working),
        .memByte (memRdData),
        .flagsIn (flags),
        .result  (aluResult)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    // next state: idle, operand read, then the optional dummy cycle
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (instrValid) begin
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (commit) begin
                    next_state = aluResult.skip ? ST_DUMMY : ST_IDLE;
                end
            end
            ST_DUMMY: begin
                if (dummyCnt == DUMMY_LAST) begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // dummy cycle counter; restarts each time a skip is taken
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dummyCnt <= CNT_ZERO;
        end else if (commit) begin
            dummyCnt <= CNT_ZERO;
        end else if (state == ST_DUMMY) begin
            dummyCnt <= dummyCnt + CNT_ONE;
        end
    end

    // capture the instruction and its address when it is taken
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            heldInstr <= '0;
            memAddr   <= '0;
        end else if (instrValid && instrReady) begin
            heldInstr <= instr;
            memAddr   <= instrAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // architectural state

    // working register: commit of a working-destination op, else a core load
    // loads are taken only while idle so an operation never sees a torn operand
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            working <= WORKING_RESET;
        end else if (commit && aluResult.toWorking) begin
            working <= aluResult.data;
        end else if (workingLoad && instrReady) begin
            working <= workingLoadData;
        end
    end

    // flags: the alu hands back old values for every flag it does not touch
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            flags <= FLAGS_RESET;
        end else if (commit) begin
            flags <= aluResult.flags;
        end else if (flagsLoad && instrReady) begin
            flags <= flagsLoadData;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory write-back

    // one-cycle write strobe after the commit; data held until the next one
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            memWrEn   <= 1'b0;
            memWrData <= BYTE_ZERO;
        end else begin
            memWrEn <= commit && aluResult.toMemory;
            if (commit && aluResult.toMemory) begin
                memWrData <= aluResult.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // skip and completion

    // skip request is a one-cycle pulse telling the sequencer to drop the
    // instruction it has fetched; the dummy flag marks the cycle that replaces it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            skipReq <= 1'b0;
        end else begin
            skipReq <= commit && aluResult.skip;
        end
    end

    assign dummyCycle = (state == ST_DUMMY);

    // done pulses one cycle after the commit, or after the last dummy cycle,
    // so a skipping instruction visibly takes the extra cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            instrDone <= 1'b0;
        end else begin
            instrDone <= (commit && !aluResult.skip) ||
                         (state == ST_DUMMY && dummyCnt == DUMMY_LAST);
        end
    end

endmodule

// >>> tb/eax_mem_model.sv
`timescale 1ns/10ps

module eax_mem_model
    import eax_pkg::*;
#(
    parameter int ADDR_W = 9
)
(
    input  wire logic              clk_sys,
    input  wire logic              memRdReq,
    input  wire logic [ADDR_W-1:0] memAddr,
    input  wire logic              memWrEn,
    input  wire logic [DATA_W-1:0] memWrData,
    input  wire logic [3:0]        rdLatency,
    output logic                   memRdValid,
    output logic [DATA_W-1:0]      memRdData
);
    logic [DATA_W-1:0] mem [2**ADDR_W];
    int                waitCnt = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // wait count of the pending read
    always @(posedge clk_sys) begin
        waitCnt <= (memRdReq && !memRdValid) ? waitCnt + 1 : 0;
        if (memWrEn) begin
            mem[memAddr] <= memWrData;
        end
    end
    // stale data shows inverted
    assign memRdValid = memRdReq && (waitCnt >= rdLatency);
    assign memRdData  = memRdValid ? mem[memAddr] : ~mem[memAddr];
endmodule

// >>> tb/eax_execute_asserts.sv
`timescale 1ns/10ps

module eax_execute_asserts
    import eax_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic              instrValid,
    input wire eax_instr_s        instr,
    input wire logic              instrReady,
    input wire logic              memRdReq,
    input wire logic              memRdValid,
    input wire logic [DATA_W-1:0] memRdData,
    input wire logic              memWrEn,
    input wire logic [DATA_W-1:0] memWrData,
    input wire logic              skipReq,
    input wire logic              dummyCycle,
    input wire logic              instrDone,
    input wire logic [DATA_W-1:0] working,
    input wire eax_flags_s        flags
);
    eax_op_e           opReg;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] accOld;
    eax_flags_s        flagsOld;
    logic              commit;

    ////////////////////////////////////////////////////////////////////////////////
    // operands frozen at commit
    always_ff @(posedge clk_sys) begin
        if (instrValid && instrReady) begin
            opReg <= instr.code;
        end
        if (commit) begin
            opnd     <= memRdData;
            accOld   <= working;
            flagsOld <= flags;
        end
    end
    assign commit = memRdReq && memRdValid;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    property p_or_working;
        commit && opReg == OP_OR_TO_WORKING |=> working == (accOld | opnd)
            && flags.zeroFlag == (working == BYTE_ZERO) && flags.carryFlag == flagsOld.carryFlag;
    endproperty
    a_or_working: assert property (p_or_working) else $error("or to working wrong");
    property p_or_memory;
        commit && opReg == OP_OR_TO_MEMORY |=> memWrEn && memWrData == (accOld | opnd);
    endproperty
    a_or_memory: assert property (p_or_memory) else $error("or to memory wrong");
    property p_rlc;
        commit && opReg == OP_ROTATE_LEFT_THRU_CARRY_MEM |=> memWrEn
            && memWrData == {opnd[6:0], flagsOld.carryFlag} && flags.carryFlag == opnd[7];
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate through carry wrong");
    property p_sub_carry;
        commit && opReg == OP_SUBTRACT_WORKING |=> flags.carryFlag == (accOld >= opnd);
    endproperty
    a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");
    property p_skip_dummy;
        skipReq |-> dummyCycle && !instrDone ##1 instrDone && !dummyCycle;
    endproperty
    a_skip_dummy: assert property (p_skip_dummy) else $error("dummy cycle wrong");
    property p_dec_skip;
        commit && opReg == OP_DECREMENT_SKIP_ZERO |=> memWrEn
            && memWrData == opnd - BYTE_ONE && skipReq == (opnd == BYTE_ONE);
    endproperty
    a_dec_skip: assert property (p_dec_skip) else $error("decrement skip wrong");
    property p_set_all;
        commit && opReg == OP_SET_ALL |=> memWrEn && memWrData == BYTE_ONES && $stable(flags);
    endproperty
    a_set_all: assert property (p_set_all) else $error("set byte wrong");
    property p_nonzero;
        commit && opReg == OP_SKIP_IF_NONZERO |=> !memWrEn && skipReq == (opnd != BYTE_ZERO);
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("byte test wrong");
    property p_swap_w;
        commit && opReg == OP_NIBBLE_EXCHANGE_WORKING |=> !memWrEn
            && working == {opnd[3:0], opnd[7:4]};
    endproperty
    a_swap_w: assert property (p_swap_w) else $error("nibble swap wrong");
endmodule

bind eax_execute eax_execute_asserts u_chk (
    .clk_sys, .rst, .instrValid, .instr, .instrReady, .memRdReq, .memRdValid, .memRdData,
    .memWrEn, .memWrData, .skipReq, .dummyCycle, .instrDone, .working, .flags
);

// >>> tb/tb.sv
`timescale 1ns/10ps

module tb;
    import eax_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              instrValid = 1'b0;
    eax_instr_s        instr = '0;
    logic [8:0]        instrAddr = '0;
    logic              workingLoad = 1'b0;
    logic [DATA_W-1:0] workingLoadData = '0;
    logic              flagsLoad = 1'b0;
    eax_flags_s        flagsLoadData = '0;
    logic [3:0]        rdLatency = '0;
    logic [2:0]        selBit = '0;
    logic              instrReady, memRdReq, memRdValid, memWrEn, skipReq, dummyCycle, instrDone;
    logic [8:0]        memAddr;
    logic [DATA_W-1:0] memRdData, memWrData, working;
    eax_flags_s        flags;
    int                num_errors = 0;
    int                n_compared = 0;
    int                cycles = 0;

    eax_execute dut (
        .clk_sys, .rst, .instrValid, .instr, .instrAddr, .instrReady, .workingLoad,
        .workingLoadData, .flagsLoad, .flagsLoadData, .memRdReq, .memAddr, .memRdValid,
        .memRdData, .memWrEn, .memWrData, .skipReq, .dummyCycle, .instrDone, .working, .flags);
    eax_mem_model mdl (
        .clk_sys, .memRdReq, .memAddr, .memWrEn, .memWrData, .rdLatency, .memRdValid, .memRdData);

    ////////////////////////////////////////////////////////////////////////////////
    always #4 clk_sys = ~clk_sys;
    // hang guard, far above the run length
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("[ERR] %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, logic [7:0] exp, string what);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chkN(input int got, int exp, string what);
        n_compared++;
        if (got != exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask
    // preload, issue once, judge every result
    task automatic op(input eax_op_e c, logic [7:0] m, a, eax_flags_s f, logic [7:0] eW, eM,
                      eax_flags_s eF, logic eS);
        int   n = 0;
        logic sk = 1'b0;
        @(negedge clk_sys);
        instrAddr = instrAddr + 9'h001;
        mdl.mem[instrAddr] = m;
        workingLoad = 1'b1;
        workingLoadData = a;
        flagsLoad = 1'b1;
        flagsLoadData = f;
        @(negedge clk_sys);
        workingLoad = 1'b0;
        flagsLoad = 1'b0;
        instr       = '{code: c, bitSel: selBit};
        instrValid  = 1'b1;
        do begin
            @(negedge clk_sys);
            instrValid = 1'b0;
            n++;
            sk |= skipReq;
        end while (instrDone !== 1'b1 && n < 20);
        // the write-back lands one edge after its strobe
        @(negedge clk_sys);
        chk8(working, eW, "working");
        chk8(mdl.mem[instrAddr], eM, "memory");
        chk8({2'b00, flags}, {2'b00, eF}, "flags");
        chk8({7'h00, sk}, {7'h00, eS}, "skip");
        chkN(n, 2 + int'(rdLatency) + int'(eS), "cycles");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk8(working, WORKING_RESET, "working");
        chk8({2'b00, flags}, 8'h00, "flags");
        chk8({7'h00, instrReady}, 8'h01, "ready");
    endtask
    task automatic t_logic();
        op(OP_OR_TO_WORKING,8'h0a,8'h50,6'h3f,8'h5a,8'h0a,6'h3d,0);
        op(OP_OR_TO_MEMORY,8'h00,8'h00,6'h00,8'h00,8'h00,6'h02,0);
        op(OP_ROTATE_LEFT_MEM,8'h81,8'h00,6'h00,8'h00,8'h03,6'h00,0);
        op(OP_ROTATE_LEFT_TO_WORKING,8'h81,8'h00,6'h3f,8'h03,8'h81,6'h3f,0);
        op(OP_ROTATE_LEFT_THRU_CARRY_MEM,8'h81,8'h00,6'h00,8'h00,8'h02,6'h01,0);
        op(OP_ROTATE_LEFT_THRU_CARRY_WORKING,8'h81,8'h00,6'h3e,8'h02,8'h81,6'h3f,0);
        op(OP_ROTATE_RIGHT_MEM,8'h81,8'h00,6'h00,8'h00,8'hc0,6'h00,0);
        op(OP_ROTATE_RIGHT_TO_WORKING,8'h81,8'h00,6'h00,8'hc0,8'h81,6'h00,0);
        op(OP_ROTATE_RIGHT_THRU_CARRY_MEM,8'h80,8'h00,6'h01,8'h00,8'hc0,6'h00,0);
        op(OP_ROTATE_RIGHT_THRU_CARRY_WORKING,8'h81,8'h00,6'h00,8'h40,8'h81,6'h01,0);
        op(OP_SUBTRACT_WORKING,8'h20,8'h10,6'h3f,8'hf0,8'h20,6'h14,0);
        op(OP_SUBTRACT_MEMORY,8'h20,8'h20,6'h00,8'h20,8'h00,6'h27,0);
        op(OP_SUBTRACT_MEMORY,8'h01,8'h80,6'h00,8'h80,8'h7f,6'h19,0);
        op(OP_SUBTRACT_BORROW_WORKING,8'h10,8'h20,6'h20,8'h0f,8'h10,6'h01,0);
        op(OP_SUBTRACT_BORROW_MEMORY,8'h10,8'h10,6'h21,8'h10,8'h00,6'h27,0);
    endtask
    task automatic t_step();
        op(OP_DECREMENT_SKIP_ZERO,8'h01,8'h00,6'h15,8'h00,8'h00,6'h15,1);
        op(OP_DECREMENT_SKIP_ZERO,8'h05,8'h00,6'h00,8'h00,8'h04,6'h00,0);
        op(OP_DECREMENT_SKIP_ZERO_WORKING,8'h05,8'h00,6'h00,8'h04,8'h05,6'h00,0);
        op(OP_DECREMENT_SKIP_ZERO_WORKING,8'h01,8'h33,6'h2a,8'h00,8'h01,6'h2a,1);
        op(OP_INCREMENT_SKIP_ZERO,8'hff,8'h00,6'h00,8'h00,8'h00,6'h00,1);
        op(OP_INCREMENT_SKIP_ZERO_WORKING,8'hff,8'h11,6'h00,8'h00,8'hff,6'h00,1);
        op(OP_INCREMENT_SKIP_ZERO_WORKING,8'h7f,8'h00,6'h00,8'h80,8'h7f,6'h00,0);
        op(OP_SET_ALL,8'h12,8'h00,6'h2a,8'h00,8'hff,6'h2a,0);
        selBit = 3'h7;
        op(OP_SET_BIT,8'h00,8'h00,6'h00,8'h00,8'h80,6'h00,0);
        selBit = 3'h5;
        op(OP_SKIP_IF_NONZERO_BIT,8'h20,8'h00,6'h00,8'h00,8'h20,6'h00,1);
        op(OP_SKIP_IF_NONZERO_BIT,8'hdf,8'h00,6'h00,8'h00,8'hdf,6'h00,0);
        selBit = 3'h0;
        op(OP_SKIP_IF_NONZERO,8'h00,8'h00,6'h00,8'h00,8'h00,6'h00,0);
        op(OP_SKIP_IF_NONZERO,8'h80,8'h00,6'h15,8'h00,8'h80,6'h15,1);
    endtask
    // operand comes two cycles late
    task automatic t_swap_slow();
        rdLatency = 4'h2;
        op(OP_NIBBLE_EXCHANGE,8'h3c,8'h00,6'h00,8'h00,8'hc3,6'h00,0);
        op(OP_NIBBLE_EXCHANGE_WORKING,8'h3c,8'h00,6'h3f,8'hc3,8'h3c,6'h3f,0);
        rdLatency = 4'h0;
    endtask

    initial begin
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        t_reset();
        t_logic();
        t_step();
        t_swap_slow();
        end_of_test();
    end
endmodule
